// ---- rtl/cmp_alu_pkg.sv ----
// Package with operation codes, flag layout and timing counts for the compare/complement datapath.
package cmp_alu_pkg;

    localparam int data_w = 16;
    localparam int byte_w = 8;
    localparam int lit_w = 8;
    // Extra stall cycles for a peripheral register access on enhanced variants.
    localparam int periph_stall_cycles = 2;
    localparam logic [15:0] zero_word = 16'h0000;
    localparam logic [4:0] flags_reset = 5'h00;

    typedef enum logic [2:0]
    {
        op_complement,
        op_compare,
        op_compare_with_borrow,
        op_compare_with_zero,
        op_none
    } alu_op_t;

    typedef enum logic [1:0]
    {
        src_file,
        src_reg,
        src_literal
    } operand_src_t;

    typedef struct packed
    {
        logic carry;
        logic zero;
        logic overflow_flag;
        logic negative;
        logic digit_carry_flag;
    } status_flags_t;

    typedef struct packed
    {
        alu_op_t op;
        logic byte_mode;
        logic dest_file;
        logic periph_access;
        logic [15:0] first_operand;
        logic [15:0] second_operand;
    } alu_request_t;

    typedef struct packed
    {
        logic write_enable;
        logic write_to_file;
        logic [15:0] result;
    } alu_result_t;

endpackage : cmp_alu_pkg

// ---- rtl/compare_complement_alu.sv ----
// Execution datapath for complement and compare operations with status flag update.
// ----------------------------------------------------------------------------
// Summary of operation
// - Compare-with-borrow subtracts exactly as subtract-with-borrow and updates flags but writes no result.
// - Compare-with-borrow takes working register zero as default operand and may clear zero but never set it.
// - One encoding bit selects word when clear and byte when set.
// - Byte operations act on the low byte only and word operations on all 16 bits.
// - Peripheral register reads and read-modify-writes on enhanced variants stall the pipeline.
// - A word compare computes first minus second, changes no register and flags signed overflow.
// ----------------------------------------------------------------------------
`timescale 1ns/1ns
module compare_complement_alu
    import cmp_alu_pkg::*;
#(
    parameter int stall_cycles = cmp_alu_pkg::periph_stall_cycles,
    parameter bit enhanced_variant = 1'b1
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic issue,
    input wire cmp_alu_pkg::alu_request_t request,
    input wire logic [15:0] default_work_reg,
    input wire logic use_default_work_reg,
    output cmp_alu_pkg::alu_result_t result,
    output cmp_alu_pkg::status_flags_t flags,
    output logic busy,
    output logic done
);
    import cmp_alu_pkg::*;

    initial
    begin
        if (stall_cycles < 1 || stall_cycles > 15)
        begin
            $error("stall_cycles must lie between 1 and 15");
        end
    end

    // ------------------------------------------------------------------------
    // Operand shaping
    // ------------------------------------------------------------------------
    function automatic logic [15:0] narrow(input logic [15:0] v, input logic byte_sel);
        narrow = byte_sel ? {8'h00, v[7:0]} : v;
    endfunction : narrow

    alu_request_t held;
    alu_request_t next_held;
    alu_request_t cur;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [15:0] diff;
    logic c_out;
    logic dc_out;
    logic ov_out;
    logic n_out;
    logic z_out;
    logic [15:0] inverted;

    always_comb
    begin
        cur = busy ? held : request;
        op_a = narrow(cur.first_operand, cur.byte_mode);
        op_b = 16'h0000;
        case (cur.op)
            op_compare:
                op_b = narrow(cur.second_operand, cur.byte_mode);
            op_compare_with_borrow:
                // Working register zero stands in when no explicit second operand is given.
                op_b = narrow(use_default_work_reg ? default_work_reg : cur.second_operand,
                    cur.byte_mode);
            op_compare_with_zero:
                op_b = zero_word;
            default:
                op_b = zero_word;
        endcase
        inverted = narrow(~cur.first_operand, cur.byte_mode);
    end

    sub_core #(.width(data_w)) u_sub
    (
        .a(op_a),
        .b(op_b),
        .borrow_in_n(cur.op == op_compare_with_borrow ? flags.carry : 1'b1),
        .byte_mode(cur.byte_mode),
        .diff(diff),
        .carry(c_out),
        .digit_carry(dc_out),
        .overflow(ov_out),
        .negative(n_out),
        .is_zero(z_out)
    );

    // ------------------------------------------------------------------------
    // Stall control
    // ------------------------------------------------------------------------
    // Only the peripheral path stalls; core registers keep single-cycle timing.
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_busy;
    logic fire;
    logic start_stall;

    always_comb
    begin
        start_stall = issue && !busy && enhanced_variant && request.periph_access
            && request.op != op_none;
        fire = 1'b0;
        next_busy = busy;
        next_count = count;
        next_held = held;
        if (start_stall)
        begin
            next_busy = 1'b1;
            next_count = 4'(stall_cycles);
            next_held = request;
        end
        else if (busy)
        begin
            next_count = count - 4'h1;
            if (count == 4'h1)
            begin
                next_busy = 1'b0;
                fire = 1'b1;
            end
        end
        else if (issue && request.op != op_none)
        begin
            fire = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Result and flags
    // ------------------------------------------------------------------------
    alu_result_t next_result;
    status_flags_t next_flags;
    logic next_done;

    always_comb
    begin
        next_result = '0;
        next_flags = flags;
        next_done = fire;
        if (fire)
        begin
            case (cur.op)
                op_complement:
                begin
                    next_result.write_enable = 1'b1;
                    next_result.write_to_file = cur.dest_file;
                    next_result.result = cur.byte_mode ? {cur.first_operand[15:8], inverted[7:0]} : inverted;
                    next_flags.negative = cur.byte_mode ? inverted[7] : inverted[15];
                    next_flags.zero = cur.byte_mode ? inverted[7:0] == 8'h00 : inverted == zero_word;
                end
                op_compare, op_compare_with_zero, op_compare_with_borrow:
                begin
                    // Compares never raise write_enable, so no register changes.
                    next_flags.carry = c_out;
                    next_flags.digit_carry_flag = dc_out;
                    next_flags.overflow_flag = ov_out;
                    next_flags.negative = n_out;
                    if (cur.op == op_compare_with_borrow)
                    begin
                        next_flags.zero = flags.zero & z_out;
                    end
                    else
                    begin
                        next_flags.zero = z_out;
                    end
                end
                default:
                    next_flags = flags;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            held <= '0;
            count <= 4'h0;
            busy <= 1'b0;
            result <= '0;
            flags <= flags_reset;
            done <= 1'b0;
        end
        else
        begin
            held <= next_held;
            count <= next_count;
            busy <= next_busy;
            result <= next_result;
            flags <= next_flags;
            done <= next_done;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_cmp_no_write: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op != op_complement) |=> !result.write_enable)
        else $error("compare wrote a result");

    a_zero_sticky: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op == op_compare_with_borrow && !flags.zero) |=> !flags.zero)
        else $error("borrow compare set zero flag");

    a_byte_high_kept: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op == op_complement && cur.byte_mode) |=>
        result.result[15:8] == $past(cur.first_operand[15:8]))
        else $error("byte complement touched high byte");

    a_stall_length: assert property (@(posedge clk) disable iff (!nrst)
        start_stall |=> busy [*2] ##0 !done)
        else $error("peripheral access did not stall");

    a_word_overflow: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op == op_compare && !cur.byte_mode) |=>
        flags.overflow_flag == (($past(cur.first_operand[15]) != $past(cur.second_operand[15]))
        && (flags.negative != $past(cur.first_operand[15]))))
        else $error("overflow flag wrong");

    a_stall_end: assert property (@(posedge clk) disable iff (!nrst)
        (busy && count == 4'h1) |=> done && !busy)
        else $error("stall did not end with completion");

    a_com_inverts: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op == op_complement && !cur.byte_mode) |=>
        result.write_enable && result.result == ~$past(cur.first_operand))
        else $error("complement result wrong");

    a_com_keeps_carry: assert property (@(posedge clk) disable iff (!nrst)
        (fire && cur.op == op_complement) |=> $stable(flags.carry) && $stable(flags.overflow_flag))
        else $error("complement changed carry or overflow");

    a_done_pulse: assert property (@(posedge clk) disable iff (!nrst)
        (done && !issue) |=> !done)
        else $error("done held without completion");

endmodule : compare_complement_alu

// ---- rtl/sub_core.sv ----
// Combinational subtractor that produces the difference and all five status flags.
`timescale 1ns/1ns
module sub_core
#(
    parameter int width = 16
)
(
    input wire logic [width-1:0] a,
    input wire logic [width-1:0] b,
    input wire logic borrow_in_n,
    input wire logic byte_mode,
    output logic [width-1:0] diff,
    output logic carry,
    output logic digit_carry,
    output logic overflow,
    output logic negative,
    output logic is_zero
);
    logic [width:0] sum;
    logic [4:0] low_nibble;
    logic sign_a;
    logic sign_b;
    logic sign_d;

    initial
    begin
        if (width != 16)
        begin
            $error("sub_core supports a width of 16 only");
        end
    end

    // Subtraction is done as a + ~b + carry so that carry out means no borrow.
    always_comb
    begin
        sum = {1'b0, a} + {1'b0, ~b} + {{width{1'b0}}, borrow_in_n};
        low_nibble = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, borrow_in_n};
        diff = sum[width-1:0];
        digit_carry = low_nibble[4];
        if (byte_mode)
        begin
            sign_a = a[7];
            sign_b = b[7];
            sign_d = diff[7];
            carry = ({1'b0, a[7:0]} + {1'b0, ~b[7:0]} + {8'h00, borrow_in_n}) >> 8 != 9'h000;
            is_zero = diff[7:0] == 8'h00;
        end
        else
        begin
            sign_a = a[width-1];
            sign_b = b[width-1];
            sign_d = diff[width-1];
            carry = sum[width];
            is_zero = diff == {width{1'b0}};
        end
        overflow = (sign_a != sign_b) && (sign_d != sign_a);
        negative = sign_d;
    end

endmodule : sub_core

// ---- test/compare_complement_alu_bench.sv ----
// Self-checking bench for the compare and complement datapath.
`timescale 1ns/1ns
module compare_complement_alu_bench;
    import cmp_alu_pkg::*;

    localparam int stall = 2;
    logic clk;
    logic nrst;
    logic issue;
    alu_request_t request;
    logic [15:0] default_work_reg;
    logic use_default_work_reg;
    alu_result_t result;
    status_flags_t flags;
    logic busy;
    logic done;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int base_lat = 0;
    status_flags_t exp_f;

    compare_complement_alu #(.stall_cycles(stall), .enhanced_variant(1'b1)) compare_complement_alu_inst
    (
        .clk(clk),
        .nrst(nrst),
        .issue(issue),
        .request(request),
        .default_work_reg(default_work_reg),
        .use_default_work_reg(use_default_work_reg),
        .result(result),
        .flags(flags),
        .busy(busy),
        .done(done)
    );

    // ----------------------------------------------------------------
    // Reference model and helpers
    // ----------------------------------------------------------------
    function automatic status_flags_t model(alu_op_t op, logic bm, logic [15:0] a, logic [15:0] b,
                                            status_flags_t f);
        status_flags_t r;
        logic [16:0] s;
        logic [4:0] n;
        logic [8:0] sb;
        logic ci;
        logic z;
        r = f;
        if (op == op_complement)
        begin
            r.negative = bm ? ~a[7] : ~a[15];
            r.zero = bm ? (a[7:0] == 8'hff) : (a == 16'hffff);
            return r;
        end
        ci = (op == op_compare_with_borrow) ? f.carry : 1'b1;
        if (op == op_compare_with_zero)
            b = 16'h0000;
        s = {1'b0, a} + {1'b0, ~b} + {16'h0000, ci};
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
        r.digit_carry_flag = n[4];
        if (bm)
        begin
            sb = {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + {8'h00, ci};
            r.carry = sb[8];
            r.negative = sb[7];
            r.overflow_flag = (a[7] != b[7]) && (sb[7] != a[7]);
            z = (sb[7:0] == 8'h00);
        end
        else
        begin
            r.carry = s[16];
            r.negative = s[15];
            r.overflow_flag = (a[15] != b[15]) && (s[15] != a[15]);
            z = (s[15:0] == 16'h0000);
        end
        // A borrow compare can only clear zero, never set it, so multi-word compares chain.
        r.zero = (op == op_compare_with_borrow) ? (f.zero & z) : z;
        return r;
    endfunction : model

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // One operation; a stalled one also tries a second issue while busy, which must be dropped.
    task automatic run_op(alu_op_t op, logic bm, logic dst, logic per, logic [15:0] a, logic [15:0] b,
                          logic [15:0] w, logic uw);
        alu_request_t rq;
        int lat;
        int nbusy;
        int extra;
        lat = 0;
        nbusy = 0;
        extra = 0;
        rq.op = op;
        rq.byte_mode = bm;
        rq.dest_file = dst;
        rq.periph_access = per;
        rq.first_operand = a;
        rq.second_operand = b;
        exp_f = model(op, bm, a, (op == op_compare_with_borrow && uw) ? w : b, exp_f);
        @(posedge clk);
        issue <= 1'b1;
        request <= rq;
        default_work_reg <= w;
        use_default_work_reg <= uw;
        @(posedge clk);
        issue <= per;
        rq.op = op_complement;
        request <= rq;
        while (done !== 1'b1 && lat < 20)
        begin
            @(negedge clk);
            lat++;
            if (busy === 1'b1)
                nbusy++;
            // The repeated issue is offered at the edge after the accepted one, then dropped.
            if (per && lat == 1)
            begin
                @(posedge clk);
                issue <= 1'b0;
            end
        end
        check("done", done, 16'h0001);
        check("flags", flags, exp_f);
        check("write_enable", result.write_enable, op == op_complement);
        if (op == op_complement)
        begin
            check("result", result.result, bm ? {a[15:8], ~a[7:0]} : ~a);
            check("write_to_file", result.write_to_file, dst);
        end
        if (per)
        begin
            check("latency", lat[15:0], base_lat[15:0] + stall[15:0]);
            check("busy cycles", nbusy[15:0], stall[15:0]);
            repeat (4)
            begin
                @(negedge clk);
                if (done === 1'b1)
                    extra++;
            end
            check("extra done", extra[15:0], 16'h0000);
        end
        else if (base_lat == 0)
            base_lat = lat;
        else
            check("latency", lat[15:0], base_lat[15:0]);
    endtask : run_op

    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        nrst = 1'b0;
        issue = 1'b0;
        request = '0;
        default_work_reg = 16'h0000;
        use_default_work_reg = 1'b0;
        exp_f = flags_reset;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("reset flags", flags, flags_reset);
        check("reset done", done, 16'h0000);
        run_op(op_compare, 1'b0, 1'b0, 1'b0, 16'h2334, 16'h8001, 16'h0000, 1'b0);
        run_op(op_compare, 1'b1, 1'b0, 1'b0, 16'h7711, 16'hff12, 16'h0000, 1'b0);
        run_op(op_compare, 1'b0, 1'b0, 1'b0, 16'h7713, 16'h0012, 16'h0000, 1'b0);
        run_op(op_complement, 1'b1, 1'b1, 1'b0, 16'h80ff, 16'h0000, 16'h0000, 1'b0);
        run_op(op_complement, 1'b0, 1'b0, 1'b0, 16'h0823, 16'h0000, 16'h0000, 1'b0);
        run_op(op_compare_with_zero, 1'b1, 1'b0, 1'b0, 16'h44c3, 16'h1234, 16'h0000, 1'b0);
        run_op(op_compare_with_zero, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h5555, 16'h0000, 1'b0);
        run_op(op_compare_with_borrow, 1'b0, 1'b0, 1'b0, 16'h2377, 16'h0001, 16'h2377, 1'b1);
        run_op(op_compare_with_borrow, 1'b0, 1'b0, 1'b0, 16'h4000, 16'h3000, 16'h0000, 1'b0);
        run_op(op_compare_with_borrow, 1'b1, 1'b0, 1'b0, 16'hab12, 16'h0000, 16'h7712, 1'b1);
        run_op(op_compare, 1'b0, 1'b0, 1'b0, 16'h0005, 16'h0006, 16'h0000, 1'b0);
        run_op(op_compare_with_borrow, 1'b0, 1'b0, 1'b0, 16'h0005, 16'h0005, 16'h0000, 1'b0);
        run_op(op_compare, 1'b0, 1'b0, 1'b1, 16'h8000, 16'h0001, 16'h0000, 1'b0);
        run_op(op_complement, 1'b0, 1'b1, 1'b1, 16'hffff, 16'h0000, 16'h0000, 1'b0);
        // An issue that carries no operation must raise neither done nor write_enable and must leave the flags alone.
        @(posedge clk);
        issue <= 1'b1;
        request.op <= op_none;
        @(posedge clk);
        issue <= 1'b0;
        @(negedge clk);
        check("none done", done, 16'h0000);
        check("none write", result.write_enable, 16'h0000);
        check("none flags", flags, exp_f);
        final_report();
    end

endmodule : compare_complement_alu_bench
